// >>> hw/periph_regs_pkg.sv
// Shared constants, offsets and carrier types for the peripheral register block
package periph_regs_pkg;

  // ----------------------------------------------------------------
  // Bus and window geometry
  // ----------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int ADDR_W = 16;
  localparam int WIN_LSB = 14;
  localparam int WORD_LSB = 2;
  localparam int NUM_PORTS = 2;
  localparam int NUM_CHAN = 4;
  localparam int STAT_W = 8;
  localparam int CMD_W = 8;
  localparam int FEN_W = 8;
  localparam int CHAR_W = 8;
  localparam int CNT_W = 16;
  localparam int STATE_W = 6;

  // ----------------------------------------------------------------
  // Register byte offsets inside a serial port window
  // ----------------------------------------------------------------
  localparam logic [13:0] OFS_CTRL = 14'h0000;
  localparam logic [13:0] OFS_MODE = 14'h0004;
  localparam logic [13:0] OFS_IRQ_EN = 14'h0008;
  localparam logic [13:0] OFS_IRQ_DIS = 14'h000C;
  localparam logic [13:0] OFS_IRQ_MASK = 14'h0010;
  localparam logic [13:0] OFS_STATUS = 14'h0014;
  localparam logic [13:0] OFS_RX_DATA = 14'h0018;
  localparam logic [13:0] OFS_TX_DATA = 14'h001C;
  localparam logic [13:0] OFS_FUNC_EN = 14'h0020;
  localparam logic [13:0] OFS_FUNC_DIS = 14'h0024;
  localparam logic [13:0] OFS_FUNC_STAT = 14'h0028;
  localparam logic [13:0] OFS_RX_PTR = 14'h0030;
  localparam logic [13:0] OFS_RX_CNT = 14'h0034;
  localparam logic [13:0] OFS_TX_PTR = 14'h0038;
  localparam logic [13:0] OFS_TX_CNT = 14'h003C;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int END_RX_BIT = 0;
  localparam int END_TX_BIT = 1;
  localparam int STATE_LSB = 2;
  localparam logic [31:0] MODE_RST = 32'h0000_0000;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] FEN_RST = 8'h00;
  localparam logic [31:0] PTR_RST = 32'h0000_0000;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [31:0] XFER_SIZE = 32'h0000_0001;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [CHAR_W-1:0] rx_data;
    logic [STATE_W-1:0] state;
  } port_in_t;

  typedef struct packed {
    logic [DATA_W-1:0] mode;
    logic [CMD_W-1:0] cmd;
    logic [FEN_W-1:0] func_en;
    logic [CHAR_W-1:0] tx_data;
    logic tx_strobe;
  } port_out_t;

endpackage : periph_regs_pkg

// >>> hw/peripheral_register_interface.sv
// Register bank for two serial ports with their transfer channels
//
// Overview of operation
// - Registers hang on a 32-bit wide peripheral bus data path.
// - Each peripheral decodes a 16 KB window.
// - Control register is write-only; ones trigger commands, zeros do nothing.
// - Mode register is read/write and resets to zero.
// - Data registers exchange receive and transmit words with the port.
// - Status register is read-only and shows the current port state.
// - Writing ones to an enable register sets matching shadow status bits.
// - Writing ones to a disable register clears matching shadow status bits.
// - Unused bits should be written zero and always read back as zero.
// - Interrupt output is OR of status bits ANDed with mask bits.
// - Mask is readable; enable writes set it, disable writes clear it.
// - Four transfer channels: receive and transmit for each of two ports.
// - Channel registers sit inside the window of the port they serve.
// - Each channel holds a 32-bit address pointer and 16-bit count.
// - Finished channel sets an end flag in port status, may interrupt.
`timescale 1ns/1ps
module peripheral_register_interface
  import periph_regs_pkg::*;
(
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire apb_req_t apb_i,
  output logic [DATA_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire port_in_t port_i [NUM_PORTS],
  output port_out_t port_o [NUM_PORTS],
  input wire logic [NUM_CHAN-1:0] xfer_done_i,
  output logic [NUM_CHAN-1:0] chan_busy_o,
  output logic [DATA_W-1:0] chan_addr_o [NUM_CHAN],
  output logic [NUM_PORTS-1:0] irq_o
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [13:0] ofs, input logic [13:0] reg_ofs);
    hit = (ofs == reg_ofs);
  endfunction : hit

  function automatic logic known(input logic [13:0] ofs);
    known = hit(ofs, OFS_CTRL) | hit(ofs, OFS_MODE) | hit(ofs, OFS_IRQ_EN) | hit(ofs, OFS_IRQ_DIS)
          | hit(ofs, OFS_IRQ_MASK) | hit(ofs, OFS_STATUS) | hit(ofs, OFS_RX_DATA) | hit(ofs, OFS_TX_DATA)
          | hit(ofs, OFS_FUNC_EN) | hit(ofs, OFS_FUNC_DIS) | hit(ofs, OFS_FUNC_STAT)
          | hit(ofs, OFS_RX_PTR) | hit(ofs, OFS_RX_CNT) | hit(ofs, OFS_TX_PTR) | hit(ofs, OFS_TX_CNT);
  endfunction : known

  // ----------------------------------------------------------------
  // Bus phase and address decode
  // ----------------------------------------------------------------
  wire access = apb_i.psel & apb_i.penable;
  wire wr = access & apb_i.pwrite;
  wire rd_setup = apb_i.psel & ~apb_i.penable & ~apb_i.pwrite;
  wire [13:0] ofs = {apb_i.paddr[WIN_LSB-1:WORD_LSB], 2'b00};
  wire win_ok = ~apb_i.paddr[ADDR_W-1];
  wire port_sel = apb_i.paddr[WIN_LSB];
  wire mapped = win_ok & known(ofs);

  logic [DATA_W-1:0] rd_val [NUM_PORTS];
  logic [STAT_W-1:0] status [NUM_PORTS];
  logic [STAT_W-1:0] mask_view [NUM_PORTS];
  logic [FEN_W-1:0] fen_view [NUM_PORTS];
  logic [DATA_W-1:0] mode_view [NUM_PORTS];
  logic [CMD_W-1:0] cmd_view [NUM_PORTS];
  logic [DATA_W-1:0] ptr_view [NUM_CHAN];
  logic [CNT_W-1:0] cnt_view [NUM_CHAN];
  logic [NUM_CHAN-1:0] chan_end;

  // ----------------------------------------------------------------
  // Per port registers
  // ----------------------------------------------------------------
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    logic [DATA_W-1:0] mode;
    logic [STAT_W-1:0] imask;
    logic [FEN_W-1:0] fen;
    logic [CMD_W-1:0] cmd;
    logic [CHAR_W-1:0] tx_data;
    logic tx_strobe;

    wire wsel = wr & win_ok & (port_sel == 1'(p));
    wire we_ctrl = wsel & hit(ofs, OFS_CTRL);
    wire we_mode = wsel & hit(ofs, OFS_MODE);
    wire we_ien = wsel & hit(ofs, OFS_IRQ_EN);
    wire we_idis = wsel & hit(ofs, OFS_IRQ_DIS);
    wire we_tx = wsel & hit(ofs, OFS_TX_DATA);
    wire we_fen = wsel & hit(ofs, OFS_FUNC_EN);
    wire we_fdis = wsel & hit(ofs, OFS_FUNC_DIS);

    wire [STAT_W-1:0] next_imask = we_ien ? (imask | apb_i.pwdata[STAT_W-1:0]) :
                                   (we_idis ? (imask & ~apb_i.pwdata[STAT_W-1:0]) : imask);
    wire [FEN_W-1:0] next_fen = we_fen ? (fen | apb_i.pwdata[FEN_W-1:0]) :
                                (we_fdis ? (fen & ~apb_i.pwdata[FEN_W-1:0]) : fen);
    wire [CMD_W-1:0] next_cmd = we_ctrl ? apb_i.pwdata[CMD_W-1:0] : '0;

    always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
        mode <= MODE_RST;
        imask <= MASK_RST;
        fen <= FEN_RST;
        cmd <= '0;
        tx_data <= '0;
        tx_strobe <= 1'b0;
      end else begin
        mode <= we_mode ? apb_i.pwdata : mode;
        imask <= next_imask;
        fen <= next_fen;
        cmd <= next_cmd;
        tx_data <= we_tx ? apb_i.pwdata[CHAR_W-1:0] : tx_data;
        tx_strobe <= we_tx;
      end
    end

    // Transfer channels of this port, receive first
    for (genvar k = 0; k < 2; k++) begin : g_chan
      localparam int C = 2 * p + k;
      wire we_ptr = wsel & hit(ofs, (k == 0) ? OFS_RX_PTR : OFS_TX_PTR);
      wire we_cnt = wsel & hit(ofs, (k == 0) ? OFS_RX_CNT : OFS_TX_CNT);

      transfer_channel u_chan (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .ptr_we_i(we_ptr),
        .cnt_we_i(we_cnt),
        .wdata_i(apb_i.pwdata),
        .done_i(xfer_done_i[C]),
        .ptr_o(ptr_view[C]),
        .cnt_o(cnt_view[C]),
        .busy_o(chan_busy_o[C]),
        .end_o(chan_end[C])
      );
      assign chan_addr_o[C] = ptr_view[C];
    end

    // Status, interrupt and read selection
    assign status[p] = {port_i[p].state, chan_end[2*p+1], chan_end[2*p]};
    assign irq_o[p] = |(status[p] & imask);
    assign mask_view[p] = imask;
    assign fen_view[p] = fen;
    assign mode_view[p] = mode;
    assign cmd_view[p] = cmd;

    assign port_o[p].mode = mode;
    assign port_o[p].cmd = cmd;
    assign port_o[p].func_en = fen;
    assign port_o[p].tx_data = tx_data;
    assign port_o[p].tx_strobe = tx_strobe;

    assign rd_val[p] =
      hit(ofs, OFS_MODE) ? mode :
      hit(ofs, OFS_IRQ_MASK) ? {24'h000000, imask} :
      hit(ofs, OFS_STATUS) ? {24'h000000, status[p]} :
      hit(ofs, OFS_RX_DATA) ? {24'h000000, port_i[p].rx_data} :
      hit(ofs, OFS_FUNC_STAT) ? {24'h000000, fen} :
      hit(ofs, OFS_RX_PTR) ? ptr_view[2*p] :
      hit(ofs, OFS_RX_CNT) ? {16'h0000, cnt_view[2*p]} :
      hit(ofs, OFS_TX_PTR) ? ptr_view[2*p+1] :
      hit(ofs, OFS_TX_CNT) ? {16'h0000, cnt_view[2*p+1]} :
      READ_ZERO;
  end

  // ----------------------------------------------------------------
  // Read data and bus answer
  // ----------------------------------------------------------------
  wire [DATA_W-1:0] sel_val = port_sel ? rd_val[1] : rd_val[0];
  wire [DATA_W-1:0] next_rdata = rd_setup ? (mapped ? sel_val : READ_ZERO) : prdata_o;

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      prdata_o <= READ_ZERO;
    end else begin
      prdata_o <= next_rdata;
    end
  end

  assign pready_o = 1'b1;
  assign pslverr_o = access & ~mapped;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  AST_UNMAPPED_ZERO: assert property (rd_setup && !win_ok |=> prdata_o == READ_ZERO)
    else $error("unmapped window did not read zero");
  AST_CTRL_READS_ZERO: assert property (rd_setup && win_ok && hit(ofs, OFS_CTRL) |=> prdata_o == READ_ZERO)
    else $error("control register did not read zero");
  AST_CMD_PULSE: assert property (wr && win_ok && !port_sel && hit(ofs, OFS_CTRL) && apb_i.pwdata[0]
                                  |=> cmd_view[0][0] ##1 !cmd_view[0][0] || (wr && hit(ofs, OFS_CTRL)))
    else $error("command bit not a single pulse");
  AST_MODE_RESET: assert property ($past(!resetn_i) |-> mode_view[0] == MODE_RST && mode_view[1] == MODE_RST)
    else $error("mode not zero after reset");
  AST_STATUS_READ: assert property (rd_setup && win_ok && !port_sel && hit(ofs, OFS_STATUS)
                                    |=> prdata_o == {24'h000000, $past(status[0])})
    else $error("status read mismatch or upper bits set");
  AST_FEN_SET: assert property (wr && win_ok && port_sel && hit(ofs, OFS_FUNC_EN) && apb_i.pwdata[3]
                                |=> fen_view[1][3])
    else $error("enable write did not set shadow bit");
  AST_FEN_CLR: assert property (wr && win_ok && port_sel && hit(ofs, OFS_FUNC_DIS) && apb_i.pwdata[3]
                                |=> !fen_view[1][3])
    else $error("disable write did not clear shadow bit");
  AST_FEN_ZERO_KEEP: assert property (wr && win_ok && port_sel && hit(ofs, OFS_FUNC_EN) && !apb_i.pwdata[2]
                                      |=> fen_view[1][2] == $past(fen_view[1][2]))
    else $error("zero bit in enable write changed shadow");
  AST_MASK_SET: assert property (wr && win_ok && !port_sel && hit(ofs, OFS_IRQ_EN) && apb_i.pwdata[END_RX_BIT]
                                 |=> mask_view[0][END_RX_BIT])
    else $error("interrupt enable did not set mask");
  AST_MASK_CLR: assert property (wr && win_ok && !port_sel && hit(ofs, OFS_IRQ_DIS) && apb_i.pwdata[END_RX_BIT]
                                 |=> !mask_view[0][END_RX_BIT] && !irq_o[0] || status[0][7:1] != 7'h00)
    else $error("interrupt disable did not clear mask");
  AST_END_IRQ: assert property (chan_end[0] && mask_view[0][END_RX_BIT] |-> irq_o[0])
    else $error("masked end flag did not interrupt");
  AST_END_FLAG: assert property (xfer_done_i[1] && cnt_view[1] == 16'h0001 && !wr |=> status[0][END_TX_BIT])
    else $error("end flag not set on last transfer");

  // ----------------------------------------------------------------
  // Register behaviour checks
  // ----------------------------------------------------------------
  AST_UNMAPPED_ERR: assert property (access && !win_ok |-> pslverr_o)
    else $error("unmapped access gave no error");
  AST_MAPPED_NO_ERR: assert property (access && win_ok && hit(ofs, OFS_MODE) |-> !pslverr_o)
    else $error("mode access flagged an error");
  AST_RO_WRITE_NO_ERR: assert property (access && win_ok && hit(ofs, OFS_STATUS) |-> !pslverr_o)
    else $error("status access flagged an error");
  AST_WORD_ONLY: assert property (rd_setup && win_ok && !port_sel
    && apb_i.paddr[WIN_LSB-1:WORD_LSB] == OFS_MODE[WIN_LSB-1:WORD_LSB] |=> prdata_o == $past(mode_view[0]))
    else $error("narrow access not read as a word");
  AST_MODE_WRITE: assert property (wr && win_ok && port_sel && hit(ofs, OFS_MODE)
    |=> mode_view[1] == $past(apb_i.pwdata))
    else $error("mode write not taken");
  AST_MODE_READ: assert property (rd_setup && win_ok && port_sel && hit(ofs, OFS_MODE)
    |=> prdata_o == $past(mode_view[1]))
    else $error("mode read mismatch");
  AST_RX_READ: assert property (rd_setup && win_ok && !port_sel && hit(ofs, OFS_RX_DATA)
    |=> prdata_o == {24'h000000, $past(port_i[0].rx_data)})
    else $error("receive data read mismatch");
  AST_TX_STROBE: assert property (wr && win_ok && !port_sel && hit(ofs, OFS_TX_DATA)
    |=> port_o[0].tx_strobe && port_o[0].tx_data == $past(apb_i.pwdata[CHAR_W-1:0]))
    else $error("transmit word not handed over");
  AST_TX_ONE_PULSE: assert property (port_o[0].tx_strobe |=> !port_o[0].tx_strobe)
    else $error("transmit strobe longer than one cycle");
  AST_TX_READS_ZERO: assert property (rd_setup && win_ok && hit(ofs, OFS_TX_DATA)
    |=> prdata_o == READ_ZERO)
    else $error("transmit data register did not read zero");
  AST_CMD_IDLE: assert property (!(wr && win_ok && !port_sel && hit(ofs, OFS_CTRL))
    |=> cmd_view[0] == 8'h00)
    else $error("command without a control write");
  AST_CMD_ZERO_BITS: assert property (wr && win_ok && !port_sel && hit(ofs, OFS_CTRL)
    |=> cmd_view[0] == $past(apb_i.pwdata[CMD_W-1:0]))
    else $error("command bits differ from written ones");
  AST_CMD_PORT1: assert property (wr && win_ok && port_sel && hit(ofs, OFS_CTRL)
    |=> port_o[1].cmd == $past(apb_i.pwdata[CMD_W-1:0]))
    else $error("second port command mismatch");
  AST_MASK_READ: assert property (rd_setup && win_ok && port_sel && hit(ofs, OFS_IRQ_MASK)
    |=> prdata_o == {24'h000000, $past(mask_view[1])})
    else $error("mask read mismatch");
  AST_MASK_EN_ALL: assert property (wr && win_ok && port_sel && hit(ofs, OFS_IRQ_EN)
    |=> mask_view[1] == ($past(mask_view[1]) | $past(apb_i.pwdata[STAT_W-1:0])))
    else $error("interrupt enable write wrong");
  AST_MASK_DIS_ALL: assert property (wr && win_ok && port_sel && hit(ofs, OFS_IRQ_DIS)
    |=> mask_view[1] == ($past(mask_view[1]) & ~$past(apb_i.pwdata[STAT_W-1:0])))
    else $error("interrupt disable write wrong");
  AST_IRQ_QUIET: assert property (mask_view[1] == 8'h00 |-> !irq_o[1])
    else $error("interrupt with empty mask");
  AST_MASK_RESET: assert property ($past(!resetn_i)
    |-> mask_view[0] == MASK_RST && mask_view[1] == MASK_RST && irq_o == 2'b00)
    else $error("mask or interrupt set after reset");
  AST_FEN_READ: assert property (rd_setup && win_ok && !port_sel && hit(ofs, OFS_FUNC_STAT)
    |=> prdata_o == {24'h000000, $past(fen_view[0])})
    else $error("shadow status read mismatch");
  AST_FEN_EN_ALL: assert property (wr && win_ok && !port_sel && hit(ofs, OFS_FUNC_EN)
    |=> fen_view[0] == ($past(fen_view[0]) | $past(apb_i.pwdata[FEN_W-1:0])))
    else $error("enable write wrong");
  AST_FEN_DIS_ALL: assert property (wr && win_ok && !port_sel && hit(ofs, OFS_FUNC_DIS)
    |=> fen_view[0] == ($past(fen_view[0]) & ~$past(apb_i.pwdata[FEN_W-1:0])))
    else $error("disable write wrong");
  AST_PTR_READ: assert property (rd_setup && win_ok && !port_sel && hit(ofs, OFS_RX_PTR)
    |=> prdata_o == $past(ptr_view[0]))
    else $error("pointer read mismatch");
  AST_CNT_READ: assert property (rd_setup && win_ok && port_sel && hit(ofs, OFS_TX_CNT)
    |=> prdata_o == {16'h0000, $past(cnt_view[3])})
    else $error("count read mismatch");
  AST_CNT_WRITE: assert property (wr && win_ok && !port_sel && hit(ofs, OFS_RX_CNT)
    |=> cnt_view[0] == $past(apb_i.pwdata[CNT_W-1:0]))
    else $error("count write not taken");
  AST_CHAN_WINDOW: assert property (wr && win_ok && !port_sel && hit(ofs, OFS_RX_PTR)
    |=> ptr_view[2] == $past(ptr_view[2]) || $past(xfer_done_i[2]))
    else $error("write reached the other port's channel");
  AST_PTR_WRITE: assert property (wr && win_ok && port_sel && hit(ofs, OFS_TX_PTR)
    |=> chan_addr_o[3] == $past(apb_i.pwdata))
    else $error("pointer write not taken");
  AST_TX_STROBE_IDLE: assert property (!(wr && win_ok && port_sel && hit(ofs, OFS_TX_DATA))
    |=> !port_o[1].tx_strobe)
    else $error("transmit strobe without a write");
  AST_BUSY_MATCH: assert property (chan_busy_o[2] |-> !status[1][END_RX_BIT])
    else $error("end flag set on a busy channel");
  AST_STATUS_READ1: assert property (rd_setup && win_ok && port_sel && hit(ofs, OFS_STATUS)
    |=> prdata_o == {24'h000000, $past(status[1])})
    else $error("second port status read mismatch");
  AST_PRDATA_HOLD: assert property (!rd_setup |=> $stable(prdata_o))
    else $error("read data changed without a read");

  COV_READ_STATUS: cover property (rd_setup && win_ok && hit(ofs, OFS_STATUS));
  COV_CMD_WRITE: cover property (wr && win_ok && hit(ofs, OFS_CTRL));
  COV_IRQ_RISE: cover property (!irq_o[0] ##1 irq_o[0]);
  COV_TX_DONE: cover property (chan_busy_o[1] ##1 !chan_busy_o[1]);

endmodule : peripheral_register_interface

// >>> hw/transfer_channel.sv
// One transfer channel: address pointer and transfer count
`timescale 1ns/1ps
module transfer_channel
  import periph_regs_pkg::*;
(
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic ptr_we_i,
  input wire logic cnt_we_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic done_i,
  output logic [DATA_W-1:0] ptr_o,
  output logic [CNT_W-1:0] cnt_o,
  output logic busy_o,
  output logic end_o
);

  // ----------------------------------------------------------------
  // Pointer and count
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] ptr;
  logic [CNT_W-1:0] cnt;
  wire step = done_i & (cnt != CNT_RST);
  wire [DATA_W-1:0] next_ptr = ptr_we_i ? wdata_i : (step ? ptr + XFER_SIZE : ptr);
  wire [CNT_W-1:0] next_cnt = cnt_we_i ? wdata_i[CNT_W-1:0] : (step ? cnt - 16'h0001 : cnt);

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      ptr <= PTR_RST;
      cnt <= CNT_RST;
    end else begin
      ptr <= next_ptr;
      cnt <= next_cnt;
    end
  end

  assign ptr_o = ptr;
  assign cnt_o = cnt;
  assign busy_o = (cnt != CNT_RST);
  assign end_o = (cnt == CNT_RST);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  AST_CNT_DEC: assert property (done_i && busy_o && !cnt_we_i |=> cnt_o == $past(cnt_o) - 16'h0001)
    else $error("count did not drop by one on a transfer");
  AST_PTR_ADV: assert property (done_i && busy_o && !ptr_we_i |=> ptr_o == $past(ptr_o) + XFER_SIZE)
    else $error("pointer did not advance by the transfer size");
  AST_STOP_AT_ZERO: assert property (end_o && !cnt_we_i && !ptr_we_i |=> end_o && $stable(ptr_o))
    else $error("channel moved after its count reached zero");
  AST_CNT_LOAD: assert property (cnt_we_i |=> cnt_o == $past(wdata_i[CNT_W-1:0]))
    else $error("count write not taken");
  COV_CHAN_END: cover property (busy_o ##1 end_o);

endmodule : transfer_channel

// >>> tb/peripheral_register_interface_tb_top.sv
// Self-checking testbench for the peripheral register block
`timescale 1ns/1ps
module peripheral_register_interface_tb_top;
  import periph_regs_pkg::*;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  apb_req_t apb = '0;
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  port_in_t port_in [NUM_PORTS];
  port_in_t port_set [NUM_PORTS];
  port_out_t port_out [NUM_PORTS];
  logic [NUM_CHAN-1:0] xfer_done;
  logic [NUM_CHAN-1:0] chan_busy;
  logic [DATA_W-1:0] chan_addr [NUM_CHAN];
  logic [NUM_PORTS-1:0] irq;
  logic [NUM_CHAN-1:0] run = '0;
  logic slow = 1'b0;
  logic [32:0] exp_q [$];
  int failures = 0;
  int tests_run = 0;
  integer seed = 4;
  logic [31:0] rnd;
  logic [31:0] ptr;
  int c;
  int n;
  always #12.5 mclk_i = ~mclk_i;
  peripheral_register_interface DUT (.mclk_i(mclk_i), .resetn_i(resetn_i), .apb_i(apb), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .port_i(port_in), .port_o(port_out), .xfer_done_i(xfer_done),
    .chan_busy_o(chan_busy), .chan_addr_o(chan_addr), .irq_o(irq));
  port_side_model partner (.mclk_i(mclk_i), .resetn_i(resetn_i), .set_i(port_set), .busy_i(chan_busy),
    .run_i(run), .slow_i(slow), .port_o(port_in), .done_o(xfer_done));
  // ----------------------------------------------------------------
  // Bus tasks and comparison
  // ----------------------------------------------------------------
  function automatic logic [15:0] ad(input int p, input logic [13:0] o);
    return {1'b0, p[0], o};
  endfunction : ad
  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge mclk_i) apb <= '{1'b1, 1'b0, 1'b1, a, d};
    @(posedge mclk_i) apb.penable <= 1'b1;
    @(posedge mclk_i) apb <= '0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [31:0] d, input logic e);
    exp_q.push_back({e, d});
    @(posedge mclk_i) apb <= '{1'b1, 1'b0, 1'b0, a, 32'h0000_0000};
    @(posedge mclk_i) apb.penable <= 1'b1;
    @(posedge mclk_i) apb <= '0;
  endtask : rd
  task automatic end_of_test();
    if (failures == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test
  // ----------------------------------------------------------------
  // Read monitor and watchdog
  // ----------------------------------------------------------------
  always @(posedge mclk_i) begin
    if (apb.psel && apb.penable && !apb.pwrite && exp_q.size() > 0) begin
      cmp({pslverr, prdata}, exp_q.pop_front());
      cmp({32'h0, pready}, 33'h0_0000_0001);
    end
  end
  initial begin
    #(25 * 20000);
    failures++;
    end_of_test();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    port_set[0] = '{8'hA5, 6'h00};
    port_set[1] = '{8'h3C, 6'h00};
    repeat (3) @(posedge mclk_i);
    resetn_i <= 1'b1;
    for (int p = 0; p < NUM_PORTS; p++) begin
      rd(ad(p, OFS_MODE), MODE_RST, 1'b0);
      rd(ad(p, OFS_STATUS), 32'h0000_0003, 1'b0);
      rd(ad(p, OFS_IRQ_MASK), 32'h0000_0000, 1'b0);
      rnd = $random(seed);
      wr(ad(p, OFS_MODE), rnd);
      #1 cmp({1'b0, port_out[p].mode}, {1'b0, rnd});
      rd(ad(p, OFS_MODE) + 16'h0003, rnd, 1'b0);
      wr(ad(p, OFS_CTRL), 32'h0000_0081);
      #1 cmp({25'h0, port_out[p].cmd}, 33'h0_0000_0081);
      rd(ad(p, OFS_CTRL), READ_ZERO, 1'b0);
      wr(ad(p, OFS_FUNC_EN), 32'h0000_00F0);
      wr(ad(p, OFS_FUNC_EN), 32'h0000_000B);
      wr(ad(p, OFS_FUNC_DIS), 32'h0000_0038);
      rd(ad(p, OFS_FUNC_STAT), 32'h0000_00C3, 1'b0);
      #1 cmp({25'h0, port_out[p].func_en}, 33'h0_0000_00C3);
      wr(ad(p, OFS_TX_DATA), 32'h0000_005A);
      #1 cmp({24'h0, port_out[p].tx_data, port_out[p].tx_strobe}, 33'h0_0000_00B5);
      rd(ad(p, OFS_TX_DATA), READ_ZERO, 1'b0);
      rd(ad(p, OFS_RX_DATA), {24'h0, port_set[p].rx_data}, 1'b0);
      @(posedge mclk_i) port_set[p].state <= 6'h05;
      wr(ad(p, OFS_STATUS), 32'h0000_0000);
      rd(ad(p, OFS_STATUS), 32'h0000_0017, 1'b0);
      wr(ad(p, OFS_IRQ_EN), 32'h0000_0004);
      #1 cmp({32'h0, irq[p]}, 33'h0_0000_0001);
      wr(ad(p, OFS_IRQ_DIS), 32'h0000_0004);
      rd(ad(p, OFS_IRQ_MASK), 32'h0000_0000, 1'b0);
      #1 cmp({32'h0, irq[p]}, 33'h0_0000_0000);
      for (int k = 0; k < 2; k++) begin
        c = 2 * p + k;
        n = 2 + k;
        ptr = $random(seed);
        wr(ad(p, k ? OFS_TX_PTR : OFS_RX_PTR), ptr);
        wr(ad(p, k ? OFS_TX_CNT : OFS_RX_CNT), n);
        rd(ad(p, OFS_STATUS), k ? 32'h0000_0015 : 32'h0000_0016, 1'b0);
        wr(ad(p, OFS_IRQ_EN), k ? 32'h0000_0002 : 32'h0000_0001);
        #1 cmp({32'h0, irq[p]}, 33'h0_0000_0000);
        @(posedge mclk_i) slow <= k[0];
        run[c] <= 1'b1;
        for (int w = 0; w < 60 && chan_busy[c] !== 1'b0; w++) @(posedge mclk_i);
        run[c] <= 1'b0;
        #1 cmp({1'b0, chan_addr[c]}, {1'b0, ptr + n});
        cmp({32'h0, irq[p]}, 33'h0_0000_0001);
        rd(ad(p, k ? OFS_TX_PTR : OFS_RX_PTR), ptr + n, 1'b0);
        rd(ad(p, k ? OFS_TX_CNT : OFS_RX_CNT), 32'h0000_0000, 1'b0);
        rd(ad(p, OFS_STATUS), 32'h0000_0017, 1'b0);
        wr(ad(p, OFS_IRQ_DIS), 32'h0000_00FF);
      end
    end
    rd(16'h8000, READ_ZERO, 1'b1);
    rd(ad(0, 14'h0040), READ_ZERO, 1'b1);
    rd(ad(1, OFS_MODE), rnd, 1'b0);
    repeat (3) @(posedge mclk_i);
    cmp({32'h0, exp_q.size() == 0}, 33'h0_0000_0001);
    end_of_test();
  end
endmodule : peripheral_register_interface_tb_top

// >>> tb/port_side_model.sv
// Behavioural model of the serial ports and transfer engine facing the register block
`timescale 1ns/1ps
module port_side_model
  import periph_regs_pkg::*;
(
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire port_in_t set_i [NUM_PORTS],
  input wire logic [NUM_CHAN-1:0] busy_i,
  input wire logic [NUM_CHAN-1:0] run_i,
  input wire logic slow_i,
  output port_in_t port_o [NUM_PORTS],
  output logic [NUM_CHAN-1:0] done_o
);
  logic [1:0] gap;
  assign port_o = set_i;
  // ----------------------------------------------------------------
  // Transfer pulses, every cycle or one in four
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      gap <= 2'h0;
      done_o <= '0;
    end else begin
      gap <= gap + 2'h1;
      done_o <= (slow_i && gap != 2'h0) ? '0 : (run_i & busy_i);
    end
  end
endmodule : port_side_model
